/* src/pmx_defs.vh */
// Register offsets, field positions and reset values for the port 3/4 pin mux
`ifndef PMX_DEFS_VH
`define PMX_DEFS_VH

// Register offsets on the plain register port
`define PMX_OFS_PIN_MODE_TWO     8'h00
`define PMX_OFS_PORT4_DATA       8'h01
`define PMX_OFS_PORT4_DIRECTION  8'h02
`define PMX_OFS_PORT3_DATA       8'h03
`define PMX_OFS_PORT3_DIRECTION  8'h04
`define PMX_OFS_PORT3_PULLUP     8'h05
`define PMX_OFS_PORT3_FUNC_SEL   8'h06

// pin_mode_two fields
`define PMX_PM2_P35_OD_BIT       5
`define PMX_PM2_WDT_CLK_BIT      2
`define PMX_PM2_RSVD_W0_BIT      1
`define PMX_PM2_EXT_INTERRUPT_ZERO_SEL_BIT         0
`define PMX_PM2_FIXED_ONES       8'hd8

// port3_function_sel fields
`define PMX_P3F_EVT_LOW_BIT      7
`define PMX_P3F_EVT_HIGH_BIT     6
`define PMX_P3F_TOVF_HIGH_BIT    2
`define PMX_P3F_TOVF_LOW_BIT     1
`define PMX_P3F_WR_MASK          8'hc6

// Port 3 pins that exist, and the open-drain pin
`define PMX_P3_PIN_MASK          8'hfe
`define PMX_P3_OD_PIN            5

// Port 3/4 read constants and the port 4 interrupt pin
`define PMX_P4_DATA_FIXED_ONES   8'hf0
`define PMX_P4_DIR_READ          8'hff
`define PMX_P3_DIR_READ          8'hfe
`define PMX_P4_IRQ_PIN           3

// Reset values
`define PMX_RST_BYTE             8'h00
`define PMX_RST_P4_PIN           4'h8
`define PMX_RST_P3_PIN           7'h00

`endif

/* src/pmx_port34.v */
// Port 3 and port 4 pin multiplexing, direction, pull-up and mode registers
`timescale 1ns/1ps
`include "pmx_defs.vh"

module pmx_port34 #(
  parameter AW = 8
) (
  input  wire          clock_i,
  input  wire          rstn_i,
  // Register port
  input  wire [AW-1:0] reg_addr_i,
  input  wire [7:0]    reg_wdata_i,
  input  wire          reg_wr_i,
  input  wire          reg_rd_i,
  output wire [7:0]    reg_rdata_o,
  // Port 3 pins
  input  wire [7:1]    p3_pin_i,
  output wire [7:1]    p3_out_o,
  output wire [7:1]    p3_oe_o,
  output wire [7:1]    p3_pullup_o,
  // Port 4 pins
  input  wire [3:0]    p4_pin_i,
  output wire [2:0]    p4_out_o,
  output wire [2:0]    p4_oe_o,
  // Serial block takeover of port 4 pins 2..0
  input  wire [2:0]    sci_claim_i,
  input  wire [2:0]    sci_out_i,
  input  wire [2:0]    sci_oe_i,
  // Alternate functions
  input  wire          tmr_ovf_high_i,
  input  wire          tmr_ovf_low_i,
  output wire          evt_low_o,
  output wire          evt_high_o,
  output wire          ext_ext_interrupt_zero_sel_n_o,
  output wire          p43_in_o,
  output wire [2:0]    p4_in_o,
  // Watchdog clock selection
  input  wire          wdt_tick_sys_i,
  input  wire          wdt_tick_sub_i,
  output wire          wdt_clock_sel_o,
  output wire          wdt_tick_o
);

  // Read mux: latched value for outputs, pin level for inputs
  function [7:0] pin_read;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
      pin_read = (dir & latch) | (~dir & pin);
    end
  endfunction

  // Address compare, kept in one place for writes and reads
  function hit;
    input [AW-1:0] addr;
    input [7:0]    ofs;
    begin
      hit = (addr == ofs[AW-1:0]);
    end
  endfunction

  // Mode bits that software can see; bit 1 is never stored, so it reads 0
  localparam [7:0] MODE_RD_MASK = (8'h01 << `PMX_PM2_P35_OD_BIT) |
                                  (8'h01 << `PMX_PM2_WDT_CLK_BIT) |
                                  (8'h01 << `PMX_PM2_EXT_INTERRUPT_ZERO_SEL_BIT);

  // Control registers
  reg [7:0] pin_mode_two_ff;
  reg [7:0] port3_data_ff;
  reg [7:0] port3_direction_ff;
  reg [7:0] port3_pullup_enable_ff;
  reg [7:0] port3_function_sel_ff;
  reg [2:0] port4_data_ff;
  reg [2:0] port4_direction_ff;
  reg [7:0] rdata_ff;

  // Registered pin drive
  reg [7:1] p3_out_ff;
  reg [7:1] p3_oe_ff;
  reg [7:1] p3_pullup_ff;
  reg [2:0] p4_out_ff;
  reg [2:0] p4_oe_ff;
  reg       evt_low_ff;
  reg       evt_high_ff;
  reg       ext_interrupt_zero_sel_n_ff;

  reg [7:1] nxt_p3_out;
  reg [7:1] nxt_p3_oe;
  reg [7:1] nxt_p3_pullup;
  reg [2:0] nxt_p4_out;
  reg [2:0] nxt_p4_oe;
  reg [7:0] nxt_rdata;

  // Synchronised pin levels; nothing reads the raw pins directly
  wire [7:1] p3_pin_s;
  wire [3:0] p4_pin_s;

  // Pins come from outside the clock domain
  pmx_sync #(
    .W       (7),
    .RST_VAL (`PMX_RST_P3_PIN)
  ) u_sync_p3 (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i (p3_pin_i),
    .sync_o  (p3_pin_s)
  );

  // Pin 4.3 starts high so the data read shows one after reset
  pmx_sync #(
    .W       (4),
    .RST_VAL (`PMX_RST_P4_PIN)
  ) u_sync_p4 (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i (p4_pin_i),
    .sync_o  (p4_pin_s)
  );

  // Decoded mode fields
  wire mode_od   = pin_mode_two_ff[`PMX_PM2_P35_OD_BIT];
  wire mode_wdt  = pin_mode_two_ff[`PMX_PM2_WDT_CLK_BIT];
  wire mode_ext_interrupt_zero_sel = pin_mode_two_ff[`PMX_PM2_EXT_INTERRUPT_ZERO_SEL_BIT];


  // Byte views for the shared read mux; absent bits are zero
  wire [7:0] p3_pin_byte = {p3_pin_s, 1'b0};
  wire [7:0] p4_dir_byte = {5'h00, port4_direction_ff};
  wire [7:0] p4_lat_byte = {5'h00, port4_data_ff};
  wire [7:0] p4_pin_byte = {4'h0, p4_pin_s};

  // Software writes; reserved bits are never stored
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      pin_mode_two_ff        <= `PMX_RST_BYTE;
      port3_data_ff          <= `PMX_RST_BYTE;
      port3_direction_ff     <= `PMX_RST_BYTE;
      port3_pullup_enable_ff <= `PMX_RST_BYTE;
      port3_function_sel_ff  <= `PMX_RST_BYTE;
      port4_data_ff          <= 3'h0;
      port4_direction_ff     <= 3'h0;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, `PMX_OFS_PIN_MODE_TWO)) begin
        // Bit 1 is kept as written zero by software, so it is not stored
        pin_mode_two_ff[`PMX_PM2_P35_OD_BIT]  <= reg_wdata_i[`PMX_PM2_P35_OD_BIT];
        pin_mode_two_ff[`PMX_PM2_WDT_CLK_BIT] <= reg_wdata_i[`PMX_PM2_WDT_CLK_BIT];
        pin_mode_two_ff[`PMX_PM2_EXT_INTERRUPT_ZERO_SEL_BIT]    <= reg_wdata_i[`PMX_PM2_EXT_INTERRUPT_ZERO_SEL_BIT];
      end
      if (hit(reg_addr_i, `PMX_OFS_PORT3_DATA)) begin
        port3_data_ff <= reg_wdata_i & `PMX_P3_PIN_MASK;
      end
      if (hit(reg_addr_i, `PMX_OFS_PORT3_DIRECTION)) begin
        port3_direction_ff <= reg_wdata_i & `PMX_P3_PIN_MASK;
      end
      if (hit(reg_addr_i, `PMX_OFS_PORT3_PULLUP)) begin
        port3_pullup_enable_ff <= reg_wdata_i & `PMX_P3_PIN_MASK;
      end
      if (hit(reg_addr_i, `PMX_OFS_PORT3_FUNC_SEL)) begin
        port3_function_sel_ff <= reg_wdata_i & `PMX_P3F_WR_MASK;
      end
      if (hit(reg_addr_i, `PMX_OFS_PORT4_DATA)) begin
        // Bit 3 is read-only, so only the three latch bits are stored
        port4_data_ff <= reg_wdata_i[2:0];
      end
      if (hit(reg_addr_i, `PMX_OFS_PORT4_DIRECTION)) begin
        port4_direction_ff <= reg_wdata_i[2:0];
      end
    end
  end

  // Read data; unmapped offsets read zero
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_rd_i) begin
      if (hit(reg_addr_i, `PMX_OFS_PIN_MODE_TWO)) begin
        nxt_rdata = `PMX_PM2_FIXED_ONES | (pin_mode_two_ff & MODE_RD_MASK);
      end else if (hit(reg_addr_i, `PMX_OFS_PORT4_DATA)) begin
        // Bit 3 has no direction bit, so it always shows the pin
        nxt_rdata = `PMX_P4_DATA_FIXED_ONES |
                    pin_read(p4_dir_byte, p4_lat_byte, p4_pin_byte);
      end else if (hit(reg_addr_i, `PMX_OFS_PORT4_DIRECTION)) begin
        nxt_rdata = `PMX_P4_DIR_READ;
      end else if (hit(reg_addr_i, `PMX_OFS_PORT3_DATA)) begin
        nxt_rdata = pin_read(port3_direction_ff, port3_data_ff, p3_pin_byte);
      end else if (hit(reg_addr_i, `PMX_OFS_PORT3_DIRECTION)) begin
        // Write-only like port 4 direction; software keeps its own copy
        nxt_rdata = `PMX_P3_DIR_READ;
      end else if (hit(reg_addr_i, `PMX_OFS_PORT3_PULLUP)) begin
        nxt_rdata = port3_pullup_enable_ff;
      end else if (hit(reg_addr_i, `PMX_OFS_PORT3_FUNC_SEL)) begin
        nxt_rdata = port3_function_sel_ff;
      end
    end
  end

  // Port 3 pin drive
  always @* begin
    nxt_p3_out    = port3_data_ff[7:1];
    nxt_p3_oe     = port3_direction_ff[7:1];
    // Pull-up follows direction and enable only; a timer pin may still ask for it
    nxt_p3_pullup = ~port3_direction_ff[7:1] & port3_pullup_enable_ff[7:1];
    // Event inputs override direction for drive only: never driven; pull-up still follows direction and enable
    if (port3_function_sel_ff[`PMX_P3F_EVT_LOW_BIT]) begin
      nxt_p3_oe[7] = 1'b0;
    end
    if (port3_function_sel_ff[`PMX_P3F_EVT_HIGH_BIT]) begin
      nxt_p3_oe[6] = 1'b0;
    end
    // Timer overflow outputs ignore the direction bit
    if (port3_function_sel_ff[`PMX_P3F_TOVF_HIGH_BIT]) begin
      nxt_p3_out[2] = tmr_ovf_high_i;
      nxt_p3_oe[2]  = 1'b1;
    end
    if (port3_function_sel_ff[`PMX_P3F_TOVF_LOW_BIT]) begin
      nxt_p3_out[1] = tmr_ovf_low_i;
      nxt_p3_oe[1]  = 1'b1;
    end
    // Open drain: PMOS off, so the pin is only ever pulled low
    if (mode_od) begin
      nxt_p3_out[`PMX_P3_OD_PIN] = 1'b0;
      nxt_p3_oe[`PMX_P3_OD_PIN]  = port3_direction_ff[`PMX_P3_OD_PIN] &
                                   ~port3_data_ff[`PMX_P3_OD_PIN];
    end
  end


  // Port 4 pin drive; serial block wins when it claims a pin
  // Claimed pins ignore the direction and data latches entirely
  always @* begin
    nxt_p4_out = (sci_claim_i & sci_out_i) | (~sci_claim_i & port4_data_ff);
    nxt_p4_oe  = (sci_claim_i & sci_oe_i) | (~sci_claim_i & port4_direction_ff);
  end


  // Outputs registered so pins never see decode glitches
  // Costs one cycle of latency on every pin drive, event and interrupt output
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_ff     <= 8'h00;
      p3_out_ff    <= 7'h00;
      p3_oe_ff     <= 7'h00;
      p3_pullup_ff <= 7'h00;
      p4_out_ff    <= 3'h0;
      p4_oe_ff     <= 3'h0;
      evt_low_ff   <= 1'b0;
      evt_high_ff  <= 1'b0;
      ext_interrupt_zero_sel_n_ff    <= 1'b1;
    end else begin
      rdata_ff     <= nxt_rdata;
      p3_out_ff    <= nxt_p3_out;
      p3_oe_ff     <= nxt_p3_oe;
      p3_pullup_ff <= nxt_p3_pullup;
      p4_out_ff    <= nxt_p4_out;
      p4_oe_ff     <= nxt_p4_oe;
      evt_low_ff   <= port3_function_sel_ff[`PMX_P3F_EVT_LOW_BIT] & p3_pin_s[7];
      evt_high_ff  <= port3_function_sel_ff[`PMX_P3F_EVT_HIGH_BIT] & p3_pin_s[6];
      // Idle high when not selected, so no false interrupt
      ext_interrupt_zero_sel_n_ff    <= mode_ext_interrupt_zero_sel ? p4_pin_s[`PMX_P4_IRQ_PIN] : 1'b1;
    end
  end

  assign reg_rdata_o  = rdata_ff;
  assign p3_out_o     = p3_out_ff;
  assign p3_oe_o      = p3_oe_ff;
  assign p3_pullup_o  = p3_pullup_ff;
  assign p4_out_o     = p4_out_ff;
  assign p4_oe_o      = p4_oe_ff;
  assign evt_low_o    = evt_low_ff;
  assign evt_high_o   = evt_high_ff;
  assign ext_ext_interrupt_zero_sel_n_o = ext_interrupt_zero_sel_n_ff;

  // General input levels, synchronised, for other blocks
  assign p43_in_o     = p4_pin_s[`PMX_P4_IRQ_PIN];
  assign p4_in_o      = p4_pin_s[2:0];


  // Watchdog tick selection; both ticks are one-cycle pulses on this clock
  // A select change mid-count may drop or add one tick
  assign wdt_clock_sel_o = mode_wdt;
  assign wdt_tick_o      = mode_wdt ? wdt_tick_sub_i : wdt_tick_sys_i;

endmodule

/* src/pmx_sync.v */
// Two-flop synchroniser for a bus of independent pin levels
`timescale 1ns/1ps

module pmx_sync #(
  parameter W       = 8,
  parameter RST_VAL = 8'h00
) (
  input  wire         clock_i,
  input  wire         rstn_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // First stage feeds only the second stage
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

/* verif/pmx_port34_props.sv */
// Port-level assertions for the port 3/4 pin mux
`timescale 1ns/1ps
module pmx_port34_props #(
  parameter AW = 8
) (
  input logic          clock_i,
  input logic          rstn_i,
  input logic [AW-1:0] reg_addr_i,
  input logic [7:0]    reg_wdata_i,
  input logic          reg_wr_i,
  input logic          reg_rd_i,
  input logic [7:0]    reg_rdata_o,
  input logic [7:1]    p3_pin_i,
  input logic [7:1]    p3_oe_o,
  input logic [7:1]    p3_pullup_o,
  input logic [3:0]    p4_pin_i,
  input logic [2:0]    sci_claim_i,
  input logic [2:0]    sci_oe_i,
  input logic [2:0]    p4_oe_o,
  input logic          evt_low_o,
  input logic          ext_ext_interrupt_zero_sel_n_o,
  input logic          wdt_tick_sys_i,
  input logic          wdt_tick_sub_i,
  input logic          wdt_clock_sel_o,
  input logic          wdt_tick_o
);
  // Decoded read slots; the answer lands one edge later
  wire rd_mode = reg_rd_i && reg_addr_i == 0;
  wire rd_p4d  = reg_rd_i && reg_addr_i == 1;
  wire rd_p4c  = reg_rd_i && reg_addr_i == 2;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read slot");
  mode_fixed_a: assert property ($past(rd_mode) |-> (reg_rdata_o & 8'hda) == 8'hd8)
    else $error("mode reserved bits wrong");
  p4dir_ones_a: assert property ($past(rd_p4c) |-> reg_rdata_o == 8'hff)
    else $error("port 4 direction read not all ones");
  p4data_ones_a: assert property ($past(rd_p4d) |-> reg_rdata_o[7:4] == 4'hf)
    else $error("port 4 data upper bits not ones");
  pullup_out_a: assert property ((p3_oe_o[7:3] & p3_pullup_o[7:3]) == 5'h00)
    else $error("pull-up on while driving");
  wdt_mux_a: assert property (wdt_tick_o == (wdt_clock_sel_o ? wdt_tick_sub_i : wdt_tick_sys_i))
    else $error("watchdog tick from wrong source");
  wdt_sel_wr_a: assert property (reg_wr_i && reg_addr_i == 0 |=>
    wdt_clock_sel_o == $past(reg_wdata_i[2])) else $error("watchdog select not written");
  evt_src_a: assert property (evt_low_o |-> $past(p3_pin_i[7], 3))
    else $error("low event input without pin level");
  irq_src_a: assert property (!ext_ext_interrupt_zero_sel_n_o |-> !$past(p4_pin_i[3], 3))
    else $error("interrupt input low without pin low");
  sci_take_a: assert property (sci_claim_i[0] |=> p4_oe_o[0] == $past(sci_oe_i[0]))
    else $error("serial claim not honoured");
  reset_pins_a: assert property (disable iff (1'b0) !rstn_i |=>
    p3_pullup_o == 7'h00 && ext_ext_interrupt_zero_sel_n_o) else $error("pins not quiet after reset");
  // Main scenarios reached
  cover property (reg_wr_i && reg_addr_i == 0);
  cover property (evt_low_o);
  cover property (!ext_ext_interrupt_zero_sel_n_o);
endmodule

bind pmx_port34 pmx_port34_props #(.AW(AW)) i_props (.*);

/* verif/tb_pmx_port34.sv */
// Self-checking bench for the port 3/4 pin mux
`timescale 1ns/1ps
`define PMX_CHK(nm, e, g) \
  begin n_checks++; if ((e) !== (g)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_pmx_port34;
  logic       clock_i, rstn_i, reg_wr_i, reg_rd_i, tmr_ovf_high_i, tmr_ovf_low_i;
  logic       wdt_tick_sys_i, wdt_tick_sub_i, evt_low_o, evt_high_o, ext_ext_interrupt_zero_sel_n_o;
  logic       p43_in_o, wdt_clock_sel_o, wdt_tick_o, od, sel_evt, sel_tmr;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v, p4d;
  logic [7:0] mode, d3, dir3, pu3, f3, d4, dir4;
  logic [7:0] wv [7];
  logic [7:1] p3_pin_i, p3_out_o, p3_oe_o, p3_pullup_o, eoe, eout;
  logic [3:0] p4_pin_i;
  logic [2:0] p4_out_o, p4_oe_o, sci_claim_i, sci_out_i, sci_oe_i, p4_in_o, eoe4, eout4;
  logic [31:0] r;
  integer     seed = 27409;
  integer     n_mismatch = 0;
  integer     n_checks = 0;
  integer     cycles = 0;
  integer     it, n;

  pmx_port34 i_dut (
    .clock_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .p3_pin_i, .p3_out_o, .p3_oe_o, .p3_pullup_o, .p4_pin_i, .p4_out_o, .p4_oe_o,
    .sci_claim_i, .sci_out_i, .sci_oe_i, .tmr_ovf_high_i, .tmr_ovf_low_i, .evt_low_o,
    .evt_high_o, .ext_ext_interrupt_zero_sel_n_o, .p43_in_o, .p4_in_o, .wdt_tick_sys_i, .wdt_tick_sub_i,
    .wdt_clock_sel_o, .wdt_tick_o
  );

  // 250 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // Hang guard, well above the roughly 1160 cycles the run needs
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One-cycle strobes; a gap cycle follows each, so no double drive
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Model the pins from the shadow registers, then read everything back
  task automatic check_all();
    for (n = 1; n < 8; n++) begin
      sel_evt = (n == 7 && f3[7]) || (n == 6 && f3[6]);
      sel_tmr = (n == 2 && f3[2]) || (n == 1 && f3[1]);
      od = n == 5 && mode[5];
      eoe[n] = sel_tmr || (!sel_evt && dir3[n] && !(od && d3[n]));
      eout[n] = sel_tmr ? (n == 2 ? tmr_ovf_high_i : tmr_ovf_low_i) : d3[n] && !od;
    end
    eoe4 = sci_claim_i & sci_oe_i | ~sci_claim_i & dir4[2:0];
    eout4 = sci_claim_i & sci_out_i | ~sci_claim_i & d4[2:0];
    p4d = {4'hf, p4_pin_i[3], dir4[2:0] & d4[2:0] | ~dir4[2:0] & p4_pin_i[2:0]};
    `PMX_CHK("p3_oe", eoe, p3_oe_o)
    `PMX_CHK("p3_out", eout & eoe, p3_out_o & p3_oe_o)
    `PMX_CHK("p3_pullup", ~dir3[7:1] & pu3[7:1], p3_pullup_o)
    `PMX_CHK("evt_low", f3[7] & p3_pin_i[7], evt_low_o)
    `PMX_CHK("evt_high", f3[6] & p3_pin_i[6], evt_high_o)
    `PMX_CHK("ext_interrupt_zero_sel_n", !mode[0] || p4_pin_i[3], ext_ext_interrupt_zero_sel_n_o)
    `PMX_CHK("p4_in", p4_pin_i, {p43_in_o, p4_in_o})
    `PMX_CHK("p4_oe", eoe4, p4_oe_o)
    `PMX_CHK("p4_out", eout4 & eoe4, p4_out_o & p4_oe_o)
    `PMX_CHK("wdt_sel", mode[2], wdt_clock_sel_o)
    `PMX_CHK("wdt_tick", mode[2] ? wdt_tick_sub_i : wdt_tick_sys_i, wdt_tick_o)
    rd(8'h00, v);
    `PMX_CHK("pin_mode_two", 8'hd8 | mode & 8'h25, v)
    rd(8'h01, v);
    `PMX_CHK("port4_data", p4d, v)
    rd(8'h02, v);
    `PMX_CHK("port4_direction", 8'hff, v)
    rd(8'h03, v);
    `PMX_CHK("port3_data", {dir3[7:1] & d3[7:1] | ~dir3[7:1] & p3_pin_i, 1'b0}, v)
    rd(8'h04, v);
    `PMX_CHK("port3_direction", 8'hfe, v)
    rd(8'h05, v);
    `PMX_CHK("port3_pullup", {pu3[7:1], 1'b0}, v)
    rd(8'h06, v);
    `PMX_CHK("port3_func", f3 & 8'hc6, v)
    rd(8'h40, v);
    `PMX_CHK("unmapped", 8'h00, v)
  endtask

  // Reset, check reset state, then random configurations
  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {p3_pin_i, p4_pin_i, sci_claim_i, sci_out_i, sci_oe_i} = '0;
    {tmr_ovf_high_i, tmr_ovf_low_i, wdt_tick_sys_i, wdt_tick_sub_i} = '0;
    {mode, d3, dir3, pu3, f3, d4, dir4} = '0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    #1;
    check_all();
    for (it = 0; it < 30; it++) begin
      mode = $random(seed) & 8'hfd;
      {d3, dir3, pu3, f3} = $random(seed);
      dir3 = dir3 & 8'hfe;
      pu3 = pu3 & 8'hfe;
      f3 = f3 & 8'hc6;
      r = $random(seed);
      {d4, dir4} = r[15:0];
      wv = '{mode, d4, dir4, d3, dir3, pu3, f3};
      for (n = 0; n < 7; n++)
        wr(n[7:0], wv[n]);
      wr(8'h10 + it[7:0], r[31:24]);
      r = $random(seed);
      @(posedge clock_i);
      {p3_pin_i, p4_pin_i, sci_claim_i, sci_out_i, sci_oe_i} <= r[19:0];
      {tmr_ovf_high_i, tmr_ovf_low_i, wdt_tick_sys_i, wdt_tick_sub_i} <= r[23:20];
      repeat (4) @(posedge clock_i);
      #1;
      check_all();
    end
    // Mid-run reset: every register and port 3 pin drive back to its reset state; serial-claimed port 4 pins still follow sci inputs
    @(posedge clock_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    {mode, d3, dir3, pu3, f3, d4, dir4} = '0;
    repeat (4) @(posedge clock_i);
    #1;
    check_all();
    final_report();
  end
endmodule
